// ===== hdl/adc_cfg_pkg.sv
// Constants shared by the converter configuration-port controller
package adc_cfg_pkg;

    // ----------------------------------------------------------------
    // Own register map, byte addresses on the AXI4-Lite bus
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_RDATA = 8'h08;
    localparam logic [7:0] REG_CTRL = 8'h0c;

    // Command word fields
    localparam int CMD_READ_BIT = 23;
    localparam int CMD_ADDR_LSB = 16;
    // Status bits
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_FOUR_WIRE_BIT = 1;
    localparam int ST_LOCK_BIT = 2;
    localparam int ST_DONE_BIT = 3;
    localparam int ST_WAKING_BIT = 4;
    // Control bits
    localparam int CTRL_HRST_BIT = 0;
    localparam int CTRL_POWER_BIT = 1;
    localparam logic CTRL_POWER_RESET = 1'b1;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // Far device: frame layout and register map
    // ----------------------------------------------------------------
    localparam int ADDR_BITS = 8;
    localparam int DATA_BITS = 16;
    localparam int FRAME_BITS = ADDR_BITS + DATA_BITS;
    localparam logic [6:0] DEV_CORRECTION_FORMAT = 7'h01;
    localparam logic [6:0] DEV_AUTO_CORRECTION = 7'h03;
    localparam logic [6:0] DEV_GENERAL_CONFIG = 7'h02;
    localparam logic [6:0] DEV_SOFT_RESET = 7'h00;
    localparam int WIRE_MODE_BIT = 15;
    localparam logic [15:0] HIGH_PERF_MASK = 16'h0002;
    localparam logic [15:0] AUTO_KEEP_MASK = 16'h0b18;
    localparam logic [15:0] SOFT_RESET_PATTERN = 16'hd2f0;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int HRST_MIN_NS = 20;
    localparam int HRST_CYC_RAW = (HRST_MIN_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int HRST_CYCLES = (HRST_CYC_RAW < 1) ? 1 : HRST_CYC_RAW;
    localparam int WAKE_TIME_US = 2500;
    localparam int WAKE_CYCLES_DOC = (WAKE_TIME_US * 1000 + CLK_PERIOD_NS
        - 1) / CLK_PERIOD_NS;
    localparam int SCLK_HALF_CYCLES = 4;

    // ----------------------------------------------------------------
    // Controller states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RESET = 3'b001,
        ST_WAKE = 3'b010,
        ST_SHIFT = 3'b011,
        ST_GAP = 3'b100
    } host_state_type;

endpackage

// ===== hdl/sync_2ff.sv
// Two-flop synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
module sync_2ff #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Asynchronous in, synchronous out
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta <= '0;
            q_o <= '0;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule

// ===== hdl/tick_gen.sv
// Half-period tick source for the serial clock divider
`timescale 1ns/1ps
module tick_gen #(
    parameter int HALF = 4
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Control and tick
    input wire logic run_i,
    output logic tick_o
);
    localparam int CW = (HALF < 2) ? 1 : $clog2(HALF);
    logic [CW-1:0] cnt;

    if (HALF < 3) begin : g_chk
        $error("tick_gen: HALF must be at least 3");
    end

    // Counter restarts whenever the frame is not running
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt <= '0;
            tick_o <= 1'b0;
        end else if (!run_i) begin
            cnt <= '0;
            tick_o <= 1'b0;
        end else if (cnt == CW'(HALF - 1)) begin
            cnt <= '0;
            tick_o <= 1'b1;
        end else begin
            cnt <= cnt + 1'b1;
            tick_o <= 1'b0;
        end
    end
endmodule

// ===== hdl/adc_cfg_host.sv
// Controller driving the converter's serial configuration port
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Notes on behaviour
// - Port starts in three-wire mode after reset
// - One three-wire write sets four-wire mode
// - Frame is 8 address plus 16 data
// - Select returns high between frames
// - Hard reset pulse low above 20 ns
// - Read flag is A7, address A6..A0
// - Read bits D15..D0 sampled on falls
// - Read flag locks writes until cleared
// - Controller sets high-performance bit in each correction-format write
// - Correction restart written one then zero; the controller passes D14 as written
// - Auto-correction bits 11,9,8,4,3 kept one
module adc_cfg_host #(
    parameter int WAKE_CYCLES = adc_cfg_pkg::WAKE_CYCLES_DOC,
    parameter int SCLK_HALF = adc_cfg_pkg::SCLK_HALF_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // AXI4-Lite write channels
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read channels
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Configuration port pins
    output logic serial_select_n_o,
    output logic sclk_o,
    output logic sdio_o,
    output logic sdio_oe_o,
    input wire logic sdio_i,
    input wire logic serial_out_line_i,
    // Device reset and power
    output logic hard_reset_n_o,
    output logic power_enable_o
);
    import adc_cfg_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    localparam int WCW = $clog2(WAKE_CYCLES + 1);

    if (WAKE_CYCLES < HRST_CYCLES || WAKE_CYCLES < 1) begin : g_chk
        $error("adc_cfg_host: WAKE_CYCLES too small");
    end

    typedef struct packed {
        host_state_type state;
        logic [WCW-1:0] wait_cnt;
        logic [4:0] bit_cnt;
        logic [FRAME_BITS-1:0] frame;
        logic [DATA_BITS-1:0] rx;
        logic [DATA_BITS-1:0] rdata_dev;
        logic [FRAME_BITS-1:0] cmd;
        logic is_read;
        logic four_wire;
        logic read_lock;
        logic done;
        logic power_en;
        logic hard_rst_n;
        logic cs_n;
        logic sclk;
        logic serial_out_line;
        logic sdo_oe;
        logic aw_hold;
        logic [7:0] aw_addr;
        logic w_hold;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic arready;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } host_regs_type;

    host_regs_type r;
    host_regs_type n;
    logic tick;
    logic [1:0] pins_sync;
    logic din;

    // ----------------------------------------------------------------
    // Pin synchronisers and serial clock divider
    // ----------------------------------------------------------------
    sync_2ff #(.WIDTH(2)) u_sync (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .d_i({serial_out_line_i, sdio_i}),
        .q_o(pins_sync)
    );

    tick_gen #(.HALF(SCLK_HALF)) u_tick (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .run_i(r.state == ST_SHIFT || r.state == ST_GAP),
        .tick_o(tick)
    );

    // Dedicated output pin carries read data once four-wire is on
    assign din = r.four_wire ? pins_sync[1] : pins_sync[0];

    // Byte-lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return res;
    endfunction

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic [31:0] wd;
        logic [6:0] dev_addr;
        logic [15:0] dev_data;
        logic rd_flag;
        logic [7:0] wa;
        logic [7:0] ra;
        wd = '0;
        dev_addr = '0;
        dev_data = '0;
        rd_flag = 1'b0;
        wa = {r.aw_addr[7:2], 2'b00};
        ra = {s_axi_araddr_i[7:2], 2'b00};
        n = r;
        unique case (r.state)
            ST_IDLE: begin
            end
            ST_RESET: begin
                n.hard_rst_n = 1'b0;
                if (r.wait_cnt >= WCW'(HRST_CYCLES - 1)) begin
                    n.hard_rst_n = 1'b1;
                    n.state = ST_IDLE;
                    n.wait_cnt = '0;
                    n.four_wire = 1'b0;
                    n.read_lock = 1'b0;
                end else begin
                    n.wait_cnt = r.wait_cnt + 1'b1;
                end
            end
            ST_WAKE: begin
                if (r.wait_cnt == '0) begin
                    n.state = ST_IDLE;
                end else begin
                    n.wait_cnt = r.wait_cnt - 1'b1;
                end
            end
            ST_SHIFT: begin
                if (tick && !r.sclk) begin
                    n.sclk = 1'b1;
                end else if (tick) begin
                    n.sclk = 1'b0;
                    if (r.is_read && r.bit_cnt < 5'd16) begin
                        n.rx = {r.rx[14:0], din};
                    end
                    if (r.bit_cnt == 5'd0) begin
                        n.state = ST_GAP;
                        n.serial_out_line = 1'b0;
                        n.sdo_oe = 1'b0;
                        n.read_lock = r.is_read;
                        if (r.is_read) begin
                            n.rdata_dev = {r.rx[14:0], din};
                        end else if (r.frame[22:16] == DEV_GENERAL_CONFIG) begin
                            n.four_wire = r.frame[WIRE_MODE_BIT];
                        end else if (r.frame[22:16] == DEV_SOFT_RESET &&
                            r.frame[15:0] == SOFT_RESET_PATTERN) begin
                            n.four_wire = 1'b0;
                        end
                    end else begin
                        n.bit_cnt = r.bit_cnt - 1'b1;
                        n.serial_out_line = r.frame[n.bit_cnt];
                        n.sdo_oe = !(r.is_read && !r.four_wire &&
                            n.bit_cnt < 5'd16);
                    end
                end
            end
            ST_GAP: begin
                if (tick && !r.cs_n) begin
                    n.cs_n = 1'b1;
                end else if (tick) begin
                    n.state = ST_IDLE;
                    n.done = 1'b1;
                end
            end
            default: n.state = ST_IDLE;
        endcase

        // AXI write address and data taken independently
        if (s_axi_awvalid_i && r.awready) begin
            n.aw_hold = 1'b1;
            n.aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && r.wready) begin
            n.w_hold = 1'b1;
            n.w_data = s_axi_wdata_i;
            n.w_strb = s_axi_wstrb_i;
        end
        if (r.bvalid && s_axi_bready_i) begin
            n.bvalid = 1'b0;
        end

        // Execute a write once both halves are held
        if (r.aw_hold && r.w_hold) begin
            n.aw_hold = 1'b0;
            n.w_hold = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = RESP_OKAY;
            if (wa == REG_CMD && r.state == ST_IDLE) begin
                wd = merge({8'h00, r.cmd}, r.w_data, r.w_strb);
                // read flag on top, address below
                rd_flag = wd[CMD_READ_BIT];
                dev_addr = wd[CMD_ADDR_LSB +: 7];
                dev_data = wd[15:0];
                if (!rd_flag && dev_addr == DEV_CORRECTION_FORMAT) begin
                    dev_data = dev_data | HIGH_PERF_MASK;
                end
                // restart bit D14 passed as written
                if (!rd_flag && dev_addr == DEV_AUTO_CORRECTION) begin
                    dev_data = dev_data | AUTO_KEEP_MASK;
                end
                n.cmd = wd[FRAME_BITS-1:0];
                n.frame = {rd_flag, dev_addr, dev_data};
                n.is_read = rd_flag;
                n.bit_cnt = 5'(FRAME_BITS - 1);
                n.cs_n = 1'b0;
                n.sclk = 1'b0;
                n.serial_out_line = rd_flag;
                n.sdo_oe = 1'b1;
                n.done = 1'b0;
                n.rx = '0;
                n.state = ST_SHIFT;
            end else if (wa == REG_CTRL && r.state == ST_IDLE) begin
                wd = merge({30'h0, r.power_en, 1'b0}, r.w_data, r.w_strb);
                n.power_en = wd[CTRL_POWER_BIT];
                if (wd[CTRL_HRST_BIT]) begin
                    n.hard_rst_n = 1'b0;
                    n.wait_cnt = '0;
                    n.state = ST_RESET;
                end else if (wd[CTRL_POWER_BIT] && !r.power_en) begin
                    n.wait_cnt = WCW'(WAKE_CYCLES - 1);
                    n.state = ST_WAKE;
                end
            end else begin
                n.bresp = RESP_SLVERR;
            end
        end

        // AXI read
        if (r.rvalid && s_axi_rready_i) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid_i && r.arready) begin
            n.rvalid = 1'b1;
            n.rresp = RESP_OKAY;
            n.rdata = '0;
            unique case (ra)
                REG_CMD: n.rdata = {8'h00, r.cmd};
                REG_STATUS: begin
                    n.rdata[ST_BUSY_BIT] = r.state != ST_IDLE;
                    n.rdata[ST_FOUR_WIRE_BIT] = r.four_wire;
                    n.rdata[ST_LOCK_BIT] = r.read_lock;
                    n.rdata[ST_DONE_BIT] = r.done;
                    n.rdata[ST_WAKING_BIT] = r.state == ST_WAKE;
                end
                REG_RDATA: n.rdata = {16'h0000, r.rdata_dev};
                REG_CTRL: n.rdata[CTRL_POWER_BIT] = r.power_en;
                default: n.rresp = RESP_SLVERR;
            endcase
        end

        // Ready flags registered so every output comes from a flop
        n.awready = !n.aw_hold && !n.bvalid;
        n.wready = !n.w_hold && !n.bvalid;
        n.arready = !n.rvalid;
    end

    // Power-up enters the hard reset sequence on its own
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r <= '0;
            r.state <= ST_RESET;
            r.cs_n <= 1'b1;
            r.power_en <= CTRL_POWER_RESET;
        end else begin
            r <= n;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign s_axi_awready_o = r.awready;
    assign s_axi_wready_o = r.wready;
    assign s_axi_bresp_o = r.bresp;
    assign s_axi_bvalid_o = r.bvalid;
    assign s_axi_arready_o = r.arready;
    assign s_axi_rdata_o = r.rdata;
    assign s_axi_rresp_o = r.rresp;
    assign s_axi_rvalid_o = r.rvalid;
    assign serial_select_n_o = r.cs_n;
    assign sclk_o = r.sclk;
    assign sdio_o = r.serial_out_line;
    assign sdio_oe_o = r.sdo_oe;
    assign hard_reset_n_o = r.hard_rst_n;
    assign power_enable_o = r.power_en;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    logic [4:0] rise_cnt;
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rise_cnt <= '0;
        end else if (r.cs_n) begin
            rise_cnt <= '0;
        end else if (n.sclk && !r.sclk) begin
            rise_cnt <= rise_cnt + 1'b1;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    a_frame_length: assert property (
        $rose(serial_select_n_o) |-> rise_cnt == 5'd24)
        else $error("frame did not carry 24 clock rises");
    a_first_bit_rw: assert property (
        $rose(sclk_o) && rise_cnt == 5'd1 |-> sdio_o == r.is_read
        && sdio_oe_o) else $error("first bit is not the read flag");
    a_select_gap: assert property (
        $rose(serial_select_n_o) |-> serial_select_n_o[*3])
        else $error("select low again too soon");
    a_reset_mode: assert property (
        $rose(hard_reset_n_o) |-> !r.four_wire && r.state == ST_IDLE)
        else $error("mode not three-wire after hard reset");
    a_read_release: assert property (
        !serial_select_n_o && r.is_read && !r.four_wire &&
        (rise_cnt > 5'd8 || (rise_cnt == 5'd8 && !sclk_o))
        |-> !sdio_oe_o) else $error("pin driven during read data");
    a_lock_track: assert property (
        $rose(serial_select_n_o) |-> r.read_lock == r.is_read)
        else $error("read lock does not follow last frame");
    a_mode_switch: assert property (
        $rose(serial_select_n_o) && !r.is_read &&
        r.frame[22:16] == DEV_GENERAL_CONFIG
        |-> r.four_wire == r.frame[WIRE_MODE_BIT])
        else $error("wire mode not taken from write");
    a_high_perf: assert property (
        !serial_select_n_o && !r.is_read &&
        r.frame[22:16] == DEV_CORRECTION_FORMAT |-> r.frame[1])
        else $error("high performance bit not set");
    a_keep_bits: assert property (
        !serial_select_n_o && !r.is_read &&
        r.frame[22:16] == DEV_AUTO_CORRECTION
        |-> (r.frame[15:0] & AUTO_KEEP_MASK) == AUTO_KEEP_MASK)
        else $error("mandatory correction bits cleared");
    a_data_stable: assert property (
        sclk_o && $past(sclk_o) |-> $stable(sdio_o))
        else $error("data moved while clock high");

    c_read_frame: cover property (
        $rose(serial_select_n_o) && r.is_read);
    c_write_frame: cover property (
        $rose(serial_select_n_o) && !r.is_read);
    c_wake: cover property ($fell(r.state == ST_WAKE));
endmodule

// ===== bench/adc_dev_model.sv
// Behavioural model of the converter's serial configuration port
`timescale 1ns/1ps
module adc_dev_model #(
    // Addresses and sensor value are arbitrary bench choices
    parameter logic [6:0] TEMP_ADDR = 7'h04,
    parameter logic [6:0] OVR_ADDR = 7'h05,
    parameter logic [8:0] TEMP_VALUE = 9'h0a5
) (
    // Pins from the controller
    input wire logic serial_select_n_i,
    input wire logic sclk_i,
    input wire logic host_bit_i,
    input wire logic host_oe_i,
    input wire logic hard_reset_n_i,
    // Pins back to the controller
    output logic pin_level_o,
    output logic out_line_o,
    // Observation for the bench
    output logic [15:0] regs_o [0:3],
    output int bits_o,
    output logic clash_o
);
    int rises = 0;
    logic [23:0] shreg = 24'h0;
    logic [15:0] word = 16'h0;
    logic dev_oe = 1'b0;
    logic dev_bit = 1'b0;
    logic last = 1'b0;
    logic lock = 1'b0;
    logic rd_frame = 1'b0;
    logic four;
    logic [15:0] ovr_reg;

    task automatic defaults();
        regs_o[0] = 16'h0000;
        regs_o[1] = 16'h0000;
        regs_o[2] = 16'h0000;
        regs_o[3] = 16'h4b18;
        ovr_reg = 16'h0780;
    endtask

    // wire mode from general config D15
    assign four = regs_o[2][15];
    // a released pin toggles, never keeps its last level
    assign pin_level_o = host_oe_i ? host_bit_i
        : ((dev_oe && !four) ? dev_bit : ~last);
    assign out_line_o = (dev_oe && four) ? dev_bit : ~last;

    initial begin
        defaults();
        bits_o = 0;
        clash_o = 1'b0;
    end
    always @(negedge hard_reset_n_i) begin
        defaults();
        lock = 1'b0;
    end
    always @(negedge serial_select_n_i) begin
        rises = 0;
        rd_frame = 1'b0;
    end
    always @(posedge serial_select_n_i) begin
        dev_oe = 1'b0;
        bits_o = rises;
    end
    always @(posedge sclk_i) begin
        last = pin_level_o;
        if (!serial_select_n_i) begin
            shreg = {shreg[22:0], pin_level_o};
            rises = rises + 1;
            if (dev_oe && host_oe_i && !four) clash_o = 1'b1;
            if (rises == 8) begin
                rd_frame = shreg[7];
                lock = lock | shreg[7];
                if (shreg[6:0] == TEMP_ADDR)
                    word = {7'h00, TEMP_VALUE};
                else if (shreg[6:0] == OVR_ADDR)
                    word = ovr_reg;
                else
                    word = (shreg[6:0] < 7'h04) ? regs_o[shreg[1:0]] : 16'h0;
            end
            // a write frame clears the lock and applies
            if (rises == 24 && !shreg[23]) begin
                lock = 1'b0;
                if (shreg[22:16] == 7'h00 && shreg[15:0] == 16'hd2f0)
                    defaults();
                else if (shreg[22:16] != 7'h00 && shreg[22:16] < 7'h04)
                    regs_o[shreg[17:16]] = shreg[15:0];
                else if (shreg[22:16] == OVR_ADDR)
                    ovr_reg = shreg[15:0];
            end
        end
    end
    // read data D15 first, changed on falling edges
    always @(negedge sclk_i) begin
        if (!serial_select_n_i && rd_frame && rises >= 8 && rises < 24) begin
            dev_oe = 1'b1;
            dev_bit = word[23-rises];
        end
    end
endmodule

// ===== bench/test_adc_cfg_host.sv
// Self-checking bench for the configuration-port controller
`timescale 1ns/1ps
module test_adc_cfg_host;
    import adc_cfg_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rd, val;
    logic awv = 1'b0, wv = 1'b0, arv = 1'b0, br = 1'b1, rr = 1'b1;
    logic awr, wr, bv, arr, rv, sel_n, sclk, so, soe, pin, oline, hrn, pwr;
    logic [1:0] bresp, rresp, resp;
    logic [15:0] dregs [0:3];
    int nbits;
    logic clash;
    int failures = 0;
    int n_tests = 0;
    // Far-side addresses and sensor value, arbitrary bench choices
    localparam logic [6:0] TEMP_ADDR = 7'h04;
    localparam logic [6:0] OVR_ADDR = 7'h05;
    localparam logic [8:0] TEMP_VALUE = 9'h0a5;

    adc_cfg_host #(.WAKE_CYCLES(20), .SCLK_HALF(4)) dut (
        .ref_clk_i(clk), .rstn_i(rstn), .s_axi_awaddr_i(awa),
        .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
        .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
        .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_rdata_o(rd), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
        .s_axi_rready_i(rr), .serial_select_n_o(sel_n), .sclk_o(sclk),
        .sdio_o(so), .sdio_oe_o(soe), .sdio_i(pin),
        .serial_out_line_i(oline), .hard_reset_n_o(hrn),
        .power_enable_o(pwr));
    adc_dev_model #(.TEMP_ADDR(TEMP_ADDR), .OVR_ADDR(OVR_ADDR),
        .TEMP_VALUE(TEMP_VALUE)) model (
        .serial_select_n_i(sel_n), .sclk_i(sclk),
        .host_bit_i(so), .host_oe_i(soe), .hard_reset_n_i(hrn),
        .pin_level_o(pin), .out_line_o(oline), .regs_o(dregs),
        .bits_o(nbits), .clash_o(clash));

    initial forever #50 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic report_and_stop();
        if (failures == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Bounded clock wait; a hang is a mismatch
    task automatic tick(inout int n);
        @(posedge clk);
        n++;
        if (n > 3000) begin
            failures++;
            report_and_stop();
        end
    endtask
    // Address and data offered together, each released when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        do begin
            tick(n);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
        end while (!bv);
        resp = bresp;
    endtask
    task automatic axr(input logic [7:0] a);
        int n = 0;
        ara <= a;
        arv <= 1'b1;
        do begin
            tick(n);
            if (arv && arr) arv <= 1'b0;
        end while (!rv);
        val = rd;
        resp = rresp;
    endtask
    task automatic idle();
        int n = 0;
        do begin
            axr(REG_STATUS);
            tick(n);
        end while (val[ST_BUSY_BIT] !== 1'b0);
    endtask
    // One device frame, then the captured word
    task automatic frame(input logic w, input logic [6:0] a,
                         input logic [15:0] d);
        axw(REG_CMD, {8'h00, w, a, d});
        idle();
        axr(REG_RDATA);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        axr(REG_STATUS);
        check(val & 32'h17, 32'h0);
        frame(1'b1, DEV_AUTO_CORRECTION, 16'h0);
        check(val, 32'h4b18);
        check(32'(nbits), 32'd24);
        check(resp, RESP_OKAY);
        axr(REG_STATUS);
        check(val[ST_LOCK_BIT], 1'b1);
        check(val[ST_DONE_BIT], 1'b1);
        frame(1'b0, DEV_CORRECTION_FORMAT, 16'h8000);
        check(dregs[1], 16'h8002);
        axr(REG_STATUS);
        check(val[ST_LOCK_BIT], 1'b0);
        frame(1'b0, TEMP_ADDR, 16'hffff);
        frame(1'b1, TEMP_ADDR, 16'h0);
        check(val, {23'h0, TEMP_VALUE});
        frame(1'b1, OVR_ADDR, 16'h0);
        check(val[10:7], 4'hf);
        frame(1'b0, DEV_AUTO_CORRECTION, 16'h4000);
        check(dregs[3], 16'h4b18);
        axw(REG_CMD, {9'h0, DEV_AUTO_CORRECTION, 16'h0});
        axw(REG_CMD, 32'h0);
        check(resp, RESP_SLVERR);
        idle();
        check(dregs[3], 16'h0b18);
        frame(1'b0, DEV_GENERAL_CONFIG, 16'hd000);
        check(dregs[2], 16'hd000);
        axr(REG_STATUS);
        check(val[ST_FOUR_WIRE_BIT], 1'b1);
        frame(1'b1, DEV_CORRECTION_FORMAT, 16'h0);
        check(val, 32'h8002);
        frame(1'b0, DEV_SOFT_RESET, SOFT_RESET_PATTERN);
        check(dregs[1], 16'h0);
        axr(REG_STATUS);
        check(val[ST_FOUR_WIRE_BIT], 1'b0);
        check(clash, 1'b0);
        axw(8'h40, 32'h0);
        check(resp, RESP_SLVERR);
        axw(REG_STATUS, 32'h0);
        check(resp, RESP_SLVERR);
        axr(8'h40);
        check(resp, RESP_SLVERR);
        axw(REG_CTRL, 32'h0);
        check(resp, RESP_OKAY);
        @(posedge clk);
        check(pwr, 1'b0);
        axw(REG_CTRL, 32'h2);
        axr(REG_STATUS);
        check(val[ST_WAKING_BIT], 1'b1);
        check(pwr, 1'b1);
        idle();
        frame(1'b0, DEV_CORRECTION_FORMAT, 16'h8000);
        axw(REG_CTRL, 32'h3);
        idle();
        check(dregs[1], 16'h0);
        report_and_stop();
    end
endmodule
